// ==== ots_output_selector.sv ====
`timescale 1ns/100ps
module ots_output_selector
	import ots_pkg::*;
(
	input  wire logic              clock_i,              // 10 MHz
	input  wire logic              resetn_i,             // async, low
	input  wire logic [FREQ_W-1:0] run_freq_i,           // running freq
	input  wire logic              running_i,            // drive runs
	input  wire logic              reverse_i,            // reverse dir
	input  wire logic              undervolt_i,          // undervoltage
	input  wire logic              load_zero_i,          // no load
	input  wire logic              fault_i,              // fault seen
	input  wire logic              freq_level_detect_two_i, // level det 2
	input  wire logic              freq_reach1_i,        // freq reach 1
	input  wire logic              freq_reach2_i,        // freq reach 2
	input  wire logic              cur_reach1_i,         // curr reach 1
	input  wire logic              cur_reach2_i,         // curr reach 2
	input  wire logic              soft_ilim_i,          // soft ilimit
	input  wire logic [TIME_W-1:0] power_on_time_i,      // accumulated
	input  wire logic [TIME_W-1:0] run_time_i,           // this run
	input  wire logic [AIN_W-1:0]  analog_input_one_i,   // level
	input  wire logic [TEMP_W-1:0] heatsink_temp_i,      // temperature
	output logic                   open_collector_output_o, // terminal
	output logic                   relay_contact_output_o,  // relay
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,       // write addr
	input  wire logic              s_axi_awvalid_i,      // addr valid
	output logic                   s_axi_awready_o,      // addr ready
	input  wire logic [31:0]       s_axi_wdata_i,        // write data
	input  wire logic [3:0]        s_axi_wstrb_i,        // byte enables
	input  wire logic              s_axi_wvalid_i,       // data valid
	output logic                   s_axi_wready_o,       // data ready
	output logic [1:0]             s_axi_bresp_o,        // write resp
	output logic                   s_axi_bvalid_o,       // resp valid
	input  wire logic              s_axi_bready_i,       // resp ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,       // read addr
	input  wire logic              s_axi_arvalid_i,      // addr valid
	output logic                   s_axi_arready_o,      // addr ready
	output logic [31:0]            s_axi_rdata_o,        // read data
	output logic [1:0]             s_axi_rresp_o,        // read resp
	output logic                   s_axi_rvalid_o,       // data valid
	input  wire logic              s_axi_rready_i        // data ready
);
	import ots_pkg::*;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = data[8*i +: 8];
			end
		end
		return res;
	endfunction

	// inclusive compare; the strict thresholds are written inline
	function automatic logic reached(input logic [FREQ_W-1:0] value,
		input logic [FREQ_W-1:0] limit);
		return value >= limit;
	endfunction

	// reset asserts at once but leaves in step with the clock,
	// so no flop sees its release close to an edge
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// software registers
	logic [CODE_W-1:0] sel_oc;
	logic [CODE_W-1:0] sel_relay;
	logic              comm_oc;
	logic              comm_relay;
	logic [FREQ_W-1:0] freq_upper;
	logic [FREQ_W-1:0] freq_lower;
	logic [TIME_W-1:0] pon_limit;
	logic [TIME_W-1:0] timing_set;
	logic              timing_en;
	logic [TIME_W-1:0] run_limit;
	logic [AIN_W-1:0]  ai_lower;
	logic [AIN_W-1:0]  ai_upper;
	logic [TEMP_W-1:0] temp_limit;

	// conditions, indexed by function code
	// a stopped drive forces codes 18, 33, 38 off and 23, 37 on
	logic [COND_N-1:0] cond;

	always_comb begin
		cond             = '0;
		cond[C_FUPPER]   = reached(run_freq_i, freq_upper);
		cond[C_FLOW_NS]  = running_i &&
			reached(freq_lower, run_freq_i);
		cond[C_UNDERV]   = undervolt_i;
		cond[C_ZSPEED2]  = !running_i ||
			(run_freq_i == '0);
		cond[C_PONTIME]  = power_on_time_i > pon_limit;
		cond[C_LEVEL2]   = freq_level_detect_two_i;
		cond[C_FREACH1]  = freq_reach1_i;
		cond[C_FREACH2]  = freq_reach2_i;
		cond[C_IREACH1]  = cur_reach1_i;
		cond[C_IREACH2]  = cur_reach2_i;
		cond[C_TIMING]   = timing_en &&
			reached(run_time_i, timing_set);
		cond[C_AILIMIT]  = (analog_input_one_i > ai_upper) ||
			(analog_input_one_i < ai_lower);
		cond[C_LOAD0]    = load_zero_i;
		cond[C_REVERSE]  = running_i && reverse_i;
		cond[C_MODTEMP]  = heatsink_temp_i >= temp_limit;
		cond[C_SOFTILM]  = soft_ilim_i;
		cond[C_FLOW_S]   = !running_i ||
			reached(freq_lower, run_freq_i);
		cond[C_ALARM]    = running_i && fault_i;
		cond[C_RUNTIME]  = run_time_i > run_limit;
	end

	// one selector per terminal, each with its own code
	// the relay comes out of reset on code 2, the open collector idle
	ots_term_sel u_sel_oc (
		.clock_i  (clock_i),
		.resetn_i (rst_n),
		.code_i   (sel_oc),
		.cond_i   (cond),
		.comm_i   (comm_oc),
		.term_o   (open_collector_output_o)
	);

	ots_term_sel u_sel_relay (
		.clock_i  (clock_i),
		.resetn_i (rst_n),
		.code_i   (sel_relay),
		.cond_i   (cond),
		.comm_i   (comm_relay),
		.term_o   (relay_contact_output_o)
	);

	// write channel: address and data captured in either order
	// commit waits for the last response to drain, so at most
	// one write response is ever pending
	logic              aw_full;
	logic              w_full;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              do_write;
	logic              aw_take;
	logic              w_take;
	logic              next_aw_full;
	logic              next_w_full;
	logic              next_bvalid;
	logic              wr_hit;

	assign aw_take  = s_axi_awvalid_i && s_axi_awready_o;
	assign w_take   = s_axi_wvalid_i && s_axi_wready_o;
	assign do_write = aw_full && w_full && !s_axi_bvalid_o;
	assign next_aw_full = aw_full ? !do_write : aw_take;
	assign next_w_full  = w_full ? !do_write : w_take;
	assign next_bvalid  = s_axi_bvalid_o ? !s_axi_bready_i : do_write;
	// only aligned, writable words are accepted
	assign wr_hit = (aw_addr <= RUNLIM_OFS || aw_addr == AILIM_OFS ||
		aw_addr == TEMPLM_OFS) && (aw_addr[1:0] == 2'h0);

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_full         <= 1'b0;
			w_full          <= 1'b0;
			aw_addr         <= '0;
			w_data          <= '0;
			w_strb          <= '0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
		end else begin
			aw_full         <= next_aw_full;
			w_full          <= next_w_full;
			s_axi_awready_o <= !next_aw_full;
			s_axi_wready_o  <= !next_w_full;
			s_axi_bvalid_o  <= next_bvalid;
			if (aw_take) begin
				aw_addr <= s_axi_awaddr_i;
			end
			if (w_take) begin
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (do_write) begin
				s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// present contents of the addressed word, so cleared byte strobes
	// leave their lanes as they were
	logic [31:0] cur_word;
	logic [31:0] new_word;

	always_comb begin
		case (aw_addr)
			SELECT_OFS: cur_word = {18'h0, sel_relay, 2'h0, sel_oc};
			COMM_OFS:   cur_word = {30'h0, comm_relay, comm_oc};
			FUPPER_OFS: cur_word = {16'h0, freq_upper};
			FLOWER_OFS: cur_word = {16'h0, freq_lower};
			PONLIM_OFS: cur_word = {16'h0, pon_limit};
			TIMING_OFS: cur_word = {15'h0, timing_en, timing_set};
			RUNLIM_OFS: cur_word = {16'h0, run_limit};
			AILIM_OFS:  cur_word = {4'h0, ai_upper, 4'h0, ai_lower};
			TEMPLM_OFS: cur_word = {24'h0, temp_limit};
			default:    cur_word = 32'h0;
		endcase
	end

	assign new_word = merge(cur_word, w_data, w_strb);

	// unmapped and read-only words fall through untouched

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sel_oc     <= SEL_OC_RST;
			sel_relay  <= SEL_RELAY_RST;
			comm_oc    <= 1'b0;
			comm_relay <= 1'b0;
			freq_upper <= FREQ_RST;
			freq_lower <= FREQ_RST;
			pon_limit  <= TIME_RST;
			timing_set <= TIME_RST;
			timing_en  <= 1'b0;
			run_limit  <= TIME_RST;
			ai_lower   <= AIN_RST;
			ai_upper   <= AIN_RST;
			temp_limit <= TEMP_RST;
		end else if (do_write) begin
			case (aw_addr)
				SELECT_OFS: begin
					sel_oc    <= new_word[SEL_OC_POS +: CODE_W];
					sel_relay <= new_word[SEL_RELAY_POS +: CODE_W];
				end
				COMM_OFS: begin
					comm_oc    <= new_word[COMM_OC_POS];
					comm_relay <= new_word[COMM_RLY_POS];
				end
				FUPPER_OFS: freq_upper <= new_word[FREQ_W-1:0];
				FLOWER_OFS: freq_lower <= new_word[FREQ_W-1:0];
				PONLIM_OFS: pon_limit  <= new_word[TIME_W-1:0];
				TIMING_OFS: begin
					timing_set <= new_word[TIME_W-1:0];
					timing_en  <= new_word[TIM_EN_POS];
				end
				RUNLIM_OFS: run_limit <= new_word[TIME_W-1:0];
				AILIM_OFS: begin
					ai_lower <= new_word[AIN_W-1:0];
					ai_upper <= new_word[AI_UP_POS +: AIN_W];
				end
				TEMPLM_OFS: temp_limit <= new_word[TEMP_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// read channel: one read at a time, data one edge after address
	// read data is a snapshot at the address edge; live conditions
	// may move again before rready
	logic        ar_take;
	logic        next_rvalid;
	logic [31:0] rd_word;
	logic        rd_hit;

	assign ar_take     = s_axi_arvalid_i && s_axi_arready_o;
	assign next_rvalid = s_axi_rvalid_o ? !s_axi_rready_i : ar_take;
	assign rd_hit      = (s_axi_araddr_i <= CONDHI_OFS) &&
		(s_axi_araddr_i[1:0] == 2'h0);

	always_comb begin
		case (s_axi_araddr_i)
			SELECT_OFS: rd_word = {18'h0, sel_relay, 2'h0, sel_oc};
			COMM_OFS:   rd_word = {30'h0, comm_relay, comm_oc};
			FUPPER_OFS: rd_word = {16'h0, freq_upper};
			FLOWER_OFS: rd_word = {16'h0, freq_lower};
			PONLIM_OFS: rd_word = {16'h0, pon_limit};
			TIMING_OFS: rd_word = {15'h0, timing_en, timing_set};
			RUNLIM_OFS: rd_word = {16'h0, run_limit};
			AILIM_OFS:  rd_word = {4'h0, ai_upper, 4'h0, ai_lower};
			TEMPLM_OFS: rd_word = {24'h0, temp_limit};
			CONDLO_OFS: rd_word = cond[31:0];
			// live conditions plus the registered terminal levels
			CONDHI_OFS: rd_word = {14'h0, relay_contact_output_o,
				open_collector_output_o, 7'h0, cond[COND_N-1:32]};
			default:    rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0;
			s_axi_rresp_o   <= RESP_OKAY;
		end else begin
			s_axi_arready_o <= !next_rvalid;
			s_axi_rvalid_o  <= next_rvalid;
			if (ar_take) begin
				s_axi_rdata_o <= rd_word;
				s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end
endmodule

// ==== ots_output_selector_sva.sv ====
`timescale 1ns/100ps
module ots_sel_sva
	import ots_pkg::*;
(
	input wire logic              clock_i,                 // clock
	input wire logic              resetn_i,                // reset
	input wire logic              running_i,               // runs
	input wire logic              reverse_i,               // reverse
	input wire logic              undervolt_i,             // undervolt
	input wire logic              fault_i,                 // fault
	input wire logic [FREQ_W-1:0] run_freq_i,              // freq
	input wire logic              open_collector_output_o, // oc
	input wire logic              relay_contact_output_o,  // relay
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,          // aw
	input wire logic              s_axi_awvalid_i,         // aw
	input wire logic              s_axi_awready_o,         // aw
	input wire logic [31:0]       s_axi_wdata_i,           // w
	input wire logic              s_axi_wvalid_i,          // w
	input wire logic              s_axi_wready_o,          // w
	input wire logic [1:0]        s_axi_bresp_o,           // b
	input wire logic              s_axi_bvalid_o,          // b
	input wire logic              s_axi_bready_i,          // b
	input wire logic              s_axi_arvalid_i,         // ar
	input wire logic              s_axi_arready_o,         // ar
	input wire logic              s_axi_rvalid_o           // r
);
	logic              busy;
	logic [ADDR_W-1:0] wa;
	logic [31:0]       wd;
	logic [CODE_W-1:0] sh_oc;
	logic [CODE_W-1:0] sh_rly;
	logic [1:0]        sh_com;
	wire               aw_hs = s_axi_awvalid_i && s_axi_awready_o;
	wire               w_hs = s_axi_wvalid_i && s_axi_wready_o;
	wire               b_hs = s_axi_bvalid_o && s_axi_bready_i;
	wire               b_ok = b_hs && s_axi_bresp_o == RESP_OKAY;

	// shadow moves at the response, so checks pause while a write is open
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy <= 1'b0;
			wa <= 6'h00;
			wd <= 32'h0;
			sh_oc <= SEL_OC_RST;
			sh_rly <= SEL_RELAY_RST;
			sh_com <= 2'h0;
		end else begin
			busy <= aw_hs || (busy && !b_hs);
			if (aw_hs) wa <= s_axi_awaddr_i;
			if (w_hs) wd <= s_axi_wdata_i;
			if (b_ok && wa == SELECT_OFS) sh_oc <= wd[5:0];
			if (b_ok && wa == SELECT_OFS) sh_rly <= wd[13:8];
			if (b_ok && wa == COMM_OFS) sh_com <= wd[1:0];
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!resetn_i);

	property p_uv;
		!busy && sh_oc == C_UNDERV |->
			open_collector_output_o == $past(undervolt_i);
	endproperty
	a_uv: assert property (p_uv)
		else $error("undervoltage terminal wrong");
	property p_comm;
		!busy && sh_oc == C_COMM |-> open_collector_output_o == sh_com[0];
	endproperty
	a_comm: assert property (p_comm)
		else $error("link-set terminal wrong");
	property p_rev;
		!busy && sh_rly == C_REVERSE |->
			relay_contact_output_o == ($past(running_i) && $past(reverse_i));
	endproperty
	a_rev: assert property (p_rev)
		else $error("reverse terminal wrong");
	property p_zs;
		!busy && sh_rly == C_ZSPEED2 |-> relay_contact_output_o ==
			(!$past(running_i) || $past(run_freq_i) == 16'h0000);
	endproperty
	a_zs: assert property (p_zs)
		else $error("zero speed terminal wrong");
	property p_alarm;
		!busy && sh_oc == C_ALARM |->
			open_collector_output_o == ($past(fault_i) && $past(running_i));
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("alarm terminal wrong");
	property p_off;
		!busy && (sh_oc inside {6'h00, 6'h15, 6'h16, 6'h27}) |->
			!open_collector_output_o;
	endproperty
	a_off: assert property (p_off)
		else $error("idle terminal active");
	property p_rd;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
	endproperty
	a_rd: assert property (p_rd)
		else $error("read answer late");
	property p_wr;
		aw_hs && w_hs |-> ##2 s_axi_bvalid_o;
	endproperty
	a_wr: assert property (p_wr)
		else $error("write answer late");

	c_uv: cover property (!busy && sh_oc == C_UNDERV && open_collector_output_o);
	c_rev: cover property (sh_rly == C_REVERSE && relay_contact_output_o);
	c_err: cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
endmodule

bind ots_output_selector ots_sel_sva u_sva (.*);

// ==== ots_pkg.sv ====
package ots_pkg;
	localparam int ADDR_W = 6;
	localparam int CODE_W = 6;
	localparam int COND_N = 41;
	localparam int FREQ_W = 16;
	localparam int TIME_W = 16;
	localparam int AIN_W  = 12;
	localparam int TEMP_W = 8;

	localparam logic [ADDR_W-1:0] SELECT_OFS = 6'h00;
	localparam logic [ADDR_W-1:0] COMM_OFS   = 6'h04;
	localparam logic [ADDR_W-1:0] FUPPER_OFS = 6'h08;
	localparam logic [ADDR_W-1:0] FLOWER_OFS = 6'h0C;
	localparam logic [ADDR_W-1:0] PONLIM_OFS = 6'h10;
	localparam logic [ADDR_W-1:0] TIMING_OFS = 6'h14;
	localparam logic [ADDR_W-1:0] RUNLIM_OFS = 6'h18;
	localparam logic [ADDR_W-1:0] AILIM_OFS  = 6'h1C;
	localparam logic [ADDR_W-1:0] TEMPLM_OFS = 6'h20;
	localparam logic [ADDR_W-1:0] CONDLO_OFS = 6'h24;
	localparam logic [ADDR_W-1:0] CONDHI_OFS = 6'h28;

	localparam int SEL_OC_POS    = 0;
	localparam int SEL_RELAY_POS = 8;
	localparam int COMM_OC_POS   = 0;
	localparam int COMM_RLY_POS  = 1;
	localparam int TIM_EN_POS    = 16;
	localparam int AI_UP_POS     = 16;
	localparam int TERM_OC_POS   = 16;
	localparam int TERM_RLY_POS  = 17;

	localparam logic [CODE_W-1:0] SEL_OC_RST    = 6'h00;
	localparam logic [CODE_W-1:0] SEL_RELAY_RST = 6'h02;
	localparam logic [FREQ_W-1:0] FREQ_RST      = 16'h0000;
	localparam logic [TIME_W-1:0] TIME_RST      = 16'h0000;
	localparam logic [AIN_W-1:0]  AIN_RST       = 12'h000;
	localparam logic [TEMP_W-1:0] TEMP_RST      = 8'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int C_NONE    = 0;
	localparam int C_FUPPER  = 17;
	localparam int C_FLOW_NS = 18;
	localparam int C_UNDERV  = 19;
	localparam int C_COMM    = 20;
	localparam int C_ZSPEED2 = 23;
	localparam int C_PONTIME = 24;
	localparam int C_LEVEL2  = 25;
	localparam int C_FREACH1 = 26;
	localparam int C_FREACH2 = 27;
	localparam int C_IREACH1 = 28;
	localparam int C_IREACH2 = 29;
	localparam int C_TIMING  = 30;
	localparam int C_AILIMIT = 31;
	localparam int C_LOAD0   = 32;
	localparam int C_REVERSE = 33;
	localparam int C_MODTEMP = 35;
	localparam int C_SOFTILM = 36;
	localparam int C_FLOW_S  = 37;
	localparam int C_ALARM   = 38;
	localparam int C_RUNTIME = 40;
endpackage

// ==== ots_term_load.sv ====
`timescale 1ns/100ps
module ots_term_load (
	input  wire logic       clock_i, // system clock
	input  wire logic       oc_i,    // open-collector line
	input  wire logic       relay_i, // relay coil
	output logic      [1:0] seen_o   // last state seen
);
	// external equipment only latches what it is shown
	always_ff @(posedge clock_i) begin
		seen_o <= {relay_i, oc_i};
	end
endmodule

// ==== ots_term_sel.sv ====
`timescale 1ns/100ps
module ots_term_sel
	import ots_pkg::*;
(
	input  wire logic              clock_i,   // system clock
	input  wire logic              resetn_i,  // synchronised reset
	input  wire logic [CODE_W-1:0] code_i,    // function selection
	input  wire logic [COND_N-1:0] cond_i,    // condition per code
	input  wire logic              comm_i,    // value from serial link
	output logic                   term_o     // registered terminal
);
	logic picked;

	// codes outside the table and reserved ones stay inactive
	assign picked = (code_i == CODE_W'(C_COMM)) ? comm_i :
		(code_i < CODE_W'(COND_N)) ? cond_i[code_i] : 1'b0;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			term_o <= 1'b0;
		end else begin
			term_o <= picked;
		end
	end
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
	import ots_pkg::*;
	localparam logic [15:0] FUP = 16'h1000;
	localparam logic [15:0] FLO = 16'h0100;
	localparam logic [15:0] PONL = 16'h0500;
	localparam logic [15:0] TSET = 16'h0300;
	localparam logic [11:0] AILO = 12'h100;
	localparam logic [11:0] AIUP = 12'h800;
	localparam logic [7:0]  TLIM = 8'h50;
	logic              clock_i, resetn_i, running_i, reverse_i, e;
	logic              undervolt_i, load_zero_i, fault_i;
	logic              freq_reach1_i, freq_reach2_i, cur_reach1_i;
	logic              cur_reach2_i, soft_ilim_i, freq_level_detect_two_i;
	logic [FREQ_W-1:0] run_freq_i;
	logic [TIME_W-1:0] power_on_time_i, run_time_i;
	logic [AIN_W-1:0]  analog_input_one_i;
	logic [TEMP_W-1:0] heatsink_temp_i;
	logic              open_collector_output_o, relay_contact_output_o;
	logic [ADDR_W-1:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0]       s_axi_wdata_i, s_axi_rdata_o;
	logic [3:0]        s_axi_wstrb_i;
	logic [1:0]        s_axi_bresp_o, s_axi_rresp_o, seen;
	logic              s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
	logic              s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
	logic              s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
	logic              s_axi_rready_i;
	int                error_cnt, samples_checked;

	ots_output_selector dut (.*);
	ots_term_load load (
		.clock_i (clock_i),
		.oc_i    (open_collector_output_o),
		.relay_i (relay_contact_output_o),
		.seen_o  (seen)
	);

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic axi_wr(input logic [5:0] a, input logic [31:0] d,
		input logic [1:0] er);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do begin
			@(posedge clock_i);
			if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (!s_axi_bvalid_o);
		check({30'h0, s_axi_bresp_o}, {30'h0, er});
		s_axi_bready_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic axi_rd(input logic [5:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do begin
			@(posedge clock_i);
			if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end while (!s_axi_rvalid_o);
		check(s_axi_rdata_o, ed);
		check({30'h0, s_axi_rresp_o}, {30'h0, er});
		s_axi_rready_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic do_reset;
		resetn_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clock_i);
	endtask

	// v0 stopped at boundaries, v1 all conditions on except codes 18, 23, 37, v2 just below limits
	task automatic set_vec(input int v);
		running_i <= v != 0;
		reverse_i <= v != 2;
		fault_i <= v != 2;
		undervolt_i <= v == 1;
		load_zero_i <= v == 1;
		{freq_level_detect_two_i, freq_reach1_i, freq_reach2_i,
			cur_reach1_i, cur_reach2_i, soft_ilim_i} <=
			v == 1 ? 6'h3F : v == 2 ? 6'h2A : 6'h00;
		run_freq_i <= v == 1 ? FUP : v == 2 ? FLO : 16'h0000;
		power_on_time_i <= v == 1 ? PONL + 16'h0001 : PONL;
		run_time_i <= v == 1 ? TSET + 16'h0001 : v == 0 ? TSET : TSET - 16'h0001;
		analog_input_one_i <= v == 1 ? AIUP + 12'h001 :
			v == 0 ? AILO : AILO - 12'h001;
		heatsink_temp_i <= v == 1 ? TLIM : TLIM - 8'h01;
	endtask

	function automatic logic expect_term(input int c, input logic cm);
		case (c)
			C_FUPPER:  return run_freq_i >= FUP;
			C_FLOW_NS: return running_i && run_freq_i <= FLO;
			C_UNDERV:  return undervolt_i;
			C_COMM:    return cm;
			C_ZSPEED2: return !running_i || run_freq_i == 16'h0000;
			C_PONTIME: return power_on_time_i > PONL;
			C_LEVEL2:  return freq_level_detect_two_i;
			C_FREACH1: return freq_reach1_i;
			C_FREACH2: return freq_reach2_i;
			C_IREACH1: return cur_reach1_i;
			C_IREACH2: return cur_reach2_i;
			C_TIMING:  return run_time_i >= TSET;
			C_AILIMIT: return analog_input_one_i > AIUP ||
				analog_input_one_i < AILO;
			C_LOAD0:   return load_zero_i;
			C_REVERSE: return running_i && reverse_i;
			C_MODTEMP: return heatsink_temp_i >= TLIM;
			C_SOFTILM: return soft_ilim_i;
			C_FLOW_S:  return !running_i || run_freq_i <= FLO;
			C_ALARM:   return running_i && fault_i;
			C_RUNTIME: return run_time_i > TSET;
			default:   return 1'b0;
		endcase
	endfunction

	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end

	initial begin
		repeat (20000) @(posedge clock_i);
		error_cnt++;
		print_verdict;
	end

	initial begin
		resetn_i = 1'b0;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
		{s_axi_arvalid_i, s_axi_rready_i} = 2'h0;
		s_axi_awaddr_i = 6'h00;
		s_axi_araddr_i = 6'h00;
		s_axi_wdata_i = 32'h0;
		s_axi_wstrb_i = 4'hF;
		set_vec(0);
		do_reset;
		axi_rd(SELECT_OFS, 32'h00000200, RESP_OKAY);
		axi_rd(6'h2C, 32'h00000000, RESP_SLVERR);
		axi_wr(CONDLO_OFS, 32'hFFFFFFFF, RESP_SLVERR);
		axi_wr(FUPPER_OFS, {16'h0, FUP}, RESP_OKAY);
		axi_wr(FLOWER_OFS, {16'h0, FLO}, RESP_OKAY);
		axi_wr(PONLIM_OFS, {16'h0, PONL}, RESP_OKAY);
		axi_wr(TIMING_OFS, {15'h0, 1'b1, TSET}, RESP_OKAY);
		axi_wr(RUNLIM_OFS, {16'h0, TSET}, RESP_OKAY);
		axi_wr(AILIM_OFS, {4'h0, AIUP, 4'h0, AILO}, RESP_OKAY);
		axi_wr(TEMPLM_OFS, {24'h0, TLIM}, RESP_OKAY);
		axi_wr(COMM_OFS, 32'h00000001, RESP_OKAY);
		axi_rd(AILIM_OFS, {4'h0, AIUP, 4'h0, AILO}, RESP_OKAY);
		// relay runs the codes backwards so the two selections differ except at code 20
		for (int c = 0; c <= 40; c++) begin
			axi_wr(SELECT_OFS, {18'h0, 6'(40 - c), 2'h0, 6'(c)}, RESP_OKAY);
			for (int v = 0; v < 3; v++) begin
				set_vec(v);
				repeat (2) @(posedge clock_i);
				e = expect_term(c, 1'b1);
				check({31'h0, open_collector_output_o}, {31'h0, e});
				e = expect_term(40 - c, 1'b0);
				check({31'h0, relay_contact_output_o}, {31'h0, e});
				@(posedge clock_i);
				check({30'h0, seen}, {30'h0, e, expect_term(c, 1'b1)});
			end
		end
		do_reset;
		axi_rd(SELECT_OFS, 32'h00000200, RESP_OKAY);
		check({31'h0, open_collector_output_o}, 32'h0);
		axi_wr(SELECT_OFS, {26'h0, 6'(C_TIMING)}, RESP_OKAY);
		set_vec(1);
		repeat (2) @(posedge clock_i);
		check({31'h0, open_collector_output_o}, 32'h0);
		axi_wr(TIMING_OFS, {15'h0, 1'b1, TSET}, RESP_OKAY);
		repeat (2) @(posedge clock_i);
		check({31'h0, open_collector_output_o}, 32'h1);
		print_verdict;
	end
endmodule
